/* File: fopt_pkg.sv */
package fopt_pkg;

  ////////////////////////////////////////////////////////////////////////////
  // Register indices as printed and their byte addresses (index times four)
  localparam logic [11:0] IDX_TRIM_INDEX = 12'hFF6;
  localparam logic [11:0] IDX_TRIM_VALUE = 12'hFF7;
  localparam logic [11:0] IDX_CONTROLLER_COMMAND = 12'hFF8;
  localparam logic [11:0] IDX_SECTOR_WRITE_GUARD = 12'hFF9;
  localparam logic [11:0] IDX_PROGRAM_TIMING_FREQ_HIGH = 12'hFFA;
  localparam logic [11:0] IDX_PROGRAM_TIMING_FREQ_LOW = 12'hFFB;

  localparam int APB_ADDR_W = 14;
  localparam logic [13:0] ADDR_TRIM_INDEX = 14'(IDX_TRIM_INDEX * 4);
  localparam logic [13:0] ADDR_TRIM_VALUE = 14'(IDX_TRIM_VALUE * 4);
  localparam logic [13:0] ADDR_CONTROLLER_COMMAND = 14'(IDX_CONTROLLER_COMMAND * 4);
  localparam logic [13:0] ADDR_SECTOR_WRITE_GUARD = 14'(IDX_SECTOR_WRITE_GUARD * 4);
  localparam logic [13:0] ADDR_FREQ_HIGH = 14'(IDX_PROGRAM_TIMING_FREQ_HIGH * 4);
  localparam logic [13:0] ADDR_FREQ_LOW = 14'(IDX_PROGRAM_TIMING_FREQ_LOW * 4);

  ////////////////////////////////////////////////////////////////////////////
  // Reset values
  localparam logic [7:0] RST_TRIM_INDEX = 8'h00;
  localparam logic [7:0] RST_GUARD = 8'h00;
  localparam logic [7:0] RST_PAGE = 8'h00;
  localparam logic [15:0] RST_FREQ = 16'h0000;
  localparam logic [7:0] RST_BYTE = 8'h00;

  ////////////////////////////////////////////////////////////////////////////
  // Controller command codes and status codes
  localparam logic [7:0] CMD_UNLOCK_FIRST = 8'h73;
  localparam logic [7:0] CMD_UNLOCK_SECOND = 8'h8C;
  localparam logic [7:0] CMD_GUARD_SELECT = 8'h5E;
  localparam logic [7:0] STAT_LOCKED = 8'h00;
  localparam logic [7:0] STAT_FIRST = 8'h01;
  localparam logic [7:0] STAT_UNLOCKED = 8'h03;
  localparam logic [7:0] STAT_GUARD_SEL = 8'h04;

  ////////////////////////////////////////////////////////////////////////////
  // Option loader and trim map
  localparam int LOAD_BYTES = 43;
  localparam int TRIM_BYTES = 32;
  localparam logic [5:0] LOAD_LAST = 6'h2A;
  localparam logic [5:0] PROG_BYTES_LAST = 6'h01;
  localparam logic [5:0] TRIM_INFO_BASE = 6'h20;
  localparam logic [7:0] TRIM_INDEX_MAX = 8'h1F;

  typedef enum logic [4:0] {
    FOPT_CTL_LOCKED = 5'b00001,
    FOPT_CTL_FIRST = 5'b00010,
    FOPT_CTL_UNLOCKED = 5'b00100,
    FOPT_CTL_GUARD_SEL = 5'b01000,
    FOPT_CTL_SPARE = 5'b10000
  } fopt_ctl_t;

  typedef enum logic [2:0] {
    FOPT_LD_READ = 3'b001,
    FOPT_LD_LATCH = 3'b010,
    FOPT_LD_DONE = 3'b100
  } fopt_ld_t;

endpackage

/* File: fopt_flash_option_protect_trim.sv */
// Implementation choice: the APB slave port.
`timescale 1ns/10ps
`default_nettype none

// What this block does
// - Shared address writes the sector guard only after 5EH while locked, else page selector
// - Guard bits reset to zero and software can never clear a set bit
// - Eight guard bits, bit 7 down to 0, one per flash sector
// - Smaller flash variants leave upper four or six guard bits unused
// - High and low timing bytes form one 16-bit timing frequency value
// - Every reset and stop recovery reloads option bytes before the processor runs
// - Changed option bytes only take effect after the next reload
// - Option configuration registers are not readable or writable by software
// - Loader makes 43 flash reads, six-bit counter on low address, rest zero
// - Option bytes latch on rising internal precision oscillator edge, 344 bits max
// - Loaded bytes 0 and 1 come from program memory, rest from information area
// - User option bytes live in program page 0 and vanish with it
// - Factory trim in information page is never altered, only volatile working copies
// - Trim index 00H-1FH selects which working byte the next data write changes
// - After an index write, the next data read returns that working byte
// - Trim indices 00H-0AH are seeded from information addresses 20h-2Ah, the rest start at zero, nothing else reachable
// - Writing 73H then 8CH unlocks; any bad value or order relocks
// - Trim data register is an 8-bit read/write window on the indexed byte
module fopt_flash_option_protect_trim #(
  parameter int GUARD_BITS_USED = 8
) (
  // Clock and reset
  input wire logic core_clk,
  input wire logic reset_n,
  // APB slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [fopt_pkg::APB_ADDR_W-1:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // Stop-mode recovery request and oscillator clock pin
  input wire logic stop_recovery,
  input wire logic internal_precision_oscillator,
  // Flash read port
  output logic [15:0] flash_addr,
  output logic flash_info_sel,
  output logic flash_rd,
  input wire logic [7:0] flash_rdata,
  // Configuration outputs
  output logic cpu_hold,
  output logic [fopt_pkg::LOAD_BYTES-1:0][7:0] option_cfg,
  output logic [fopt_pkg::TRIM_BYTES-1:0][7:0] trim_work,
  output logic [7:0] sector_guard_bit,
  output logic [7:0] page_selector,
  output logic [15:0] program_timing_freq
);

  ////////////////////////////////////////////////////////////////////////////
  // Unused guard bits are forced low on smaller parts
  localparam logic [7:0] GUARD_MASK = 8'((9'h001 << GUARD_BITS_USED) - 9'h001);

  fopt_pkg::fopt_ctl_t ctl_q, ctl_d;
  fopt_pkg::fopt_ld_t ld_q, ld_d;
  logic [5:0] count_q, count_d;
  logic [15:0] faddr_q, faddr_d;
  logic finfo_q, finfo_d;
  logic frd_q, frd_d;
  logic frd_dly_q;
  logic [7:0] buf_q, buf_d;
  logic got_q, got_d;
  logic busy_q, busy_d;
  logic [fopt_pkg::LOAD_BYTES-1:0][7:0] opt_q, opt_d;
  logic [fopt_pkg::TRIM_BYTES-1:0][7:0] trim_q, trim_d;
  logic [7:0] tidx_q, tidx_d;
  logic [7:0] guard_q, guard_d;
  logic [7:0] page_q, page_d;
  logic [15:0] freq_q, freq_d;
  logic [31:0] prdata_q, prdata_d;
  logic pready_q, pready_d;
  logic pslverr_q, pslverr_d;
  logic ipo_s1_q, ipo_s2_q, ipo_s3_q;
  logic ipo_rise;
  logic setup_ph, wr_done;
  logic [7:0] wbyte;
  logic [7:0] stat_byte;
  logic addr_hit;
  logic [5:0] trim_slot;

  ////////////////////////////////////////////////////////////////////////////
  // Oscillator pin comes from another domain, so two stages before use
  always_ff @(posedge core_clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      ipo_s1_q <= 1'b0;
      ipo_s2_q <= 1'b0;
      ipo_s3_q <= 1'b0;
    end
    else
    begin
      ipo_s1_q <= internal_precision_oscillator;
      ipo_s2_q <= ipo_s1_q;
      ipo_s3_q <= ipo_s2_q;
    end
  end

  // Rising edge seen on the synchronised copy only
  assign ipo_rise = ipo_s2_q & ~ipo_s3_q;

  ////////////////////////////////////////////////////////////////////////////
  // Bus phase decode; writes land only at the completing access edge
  assign setup_ph = psel & ~penable;
  assign wr_done = psel & penable & pready_q & pwrite & ~pslverr_q;
  assign wbyte = pwdata[7:0];

  // Status code as software sees it at the command address
  always_comb
  begin
    case (ctl_q)
      fopt_pkg::FOPT_CTL_LOCKED: stat_byte = fopt_pkg::STAT_LOCKED;
      fopt_pkg::FOPT_CTL_FIRST: stat_byte = fopt_pkg::STAT_FIRST;
      fopt_pkg::FOPT_CTL_UNLOCKED: stat_byte = fopt_pkg::STAT_UNLOCKED;
      fopt_pkg::FOPT_CTL_GUARD_SEL: stat_byte = fopt_pkg::STAT_GUARD_SEL;
      default: stat_byte = fopt_pkg::STAT_LOCKED;
    endcase
  end

  // Address match for the six mapped words
  always_comb
  begin
    case (paddr)
      fopt_pkg::ADDR_TRIM_INDEX: addr_hit = 1'b1;
      fopt_pkg::ADDR_TRIM_VALUE: addr_hit = 1'b1;
      fopt_pkg::ADDR_CONTROLLER_COMMAND: addr_hit = 1'b1;
      fopt_pkg::ADDR_SECTOR_WRITE_GUARD: addr_hit = 1'b1;
      fopt_pkg::ADDR_FREQ_HIGH: addr_hit = 1'b1;
      fopt_pkg::ADDR_FREQ_LOW: addr_hit = 1'b1;
      default: addr_hit = 1'b0;
    endcase
  end

  ////////////////////////////////////////////////////////////////////////////
  // Bus answer: read data and ready are prepared in the setup cycle so that
  // they leave from flops; the access then completes with no wait state.
  // While the loader runs the bus is held off, which also keeps the
  // processor from touching anything before the options are in place.
  always_comb
  begin
    prdata_d = prdata_q;
    pready_d = 1'b0;
    pslverr_d = 1'b0;
    if (setup_ph && !busy_q)
    begin
      pready_d = 1'b1;
      pslverr_d = ~addr_hit;
      prdata_d = 32'h0000_0000;
      if (!pwrite)
      begin
        case (paddr)
          fopt_pkg::ADDR_TRIM_INDEX: prdata_d = {24'h00_0000, tidx_q};
          fopt_pkg::ADDR_TRIM_VALUE:
          begin
            // Out-of-range index reads zero, nothing else is reachable
            if (tidx_q <= fopt_pkg::TRIM_INDEX_MAX)
            begin
              prdata_d = {24'h00_0000, trim_q[tidx_q[4:0]]};
            end
          end
          fopt_pkg::ADDR_CONTROLLER_COMMAND: prdata_d = {24'h00_0000, stat_byte};
          fopt_pkg::ADDR_SECTOR_WRITE_GUARD:
          begin
            // Guard view while selected, page selector otherwise
            if (ctl_q == fopt_pkg::FOPT_CTL_GUARD_SEL)
            begin
              prdata_d = {24'h00_0000, guard_q & GUARD_MASK};
            end
            else
            begin
              prdata_d = {24'h00_0000, page_q};
            end
          end
          fopt_pkg::ADDR_FREQ_HIGH: prdata_d = {24'h00_0000, freq_q[15:8]};
          fopt_pkg::ADDR_FREQ_LOW: prdata_d = {24'h00_0000, freq_q[7:0]};
          default: prdata_d = 32'h0000_0000;
        endcase
      end
    end
  end

  always_ff @(posedge core_clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      prdata_q <= 32'h0000_0000;
      pready_q <= 1'b0;
      pslverr_q <= 1'b0;
    end
    else
    begin
      prdata_q <= prdata_d;
      pready_q <= pready_d;
      pslverr_q <= pslverr_d;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Controller lock sequence; only the part that steers the shared address
  // is kept here, erase sequencing lives elsewhere
  always_comb
  begin
    ctl_d = ctl_q;
    if (wr_done && paddr == fopt_pkg::ADDR_CONTROLLER_COMMAND)
    begin
      case (ctl_q)
        fopt_pkg::FOPT_CTL_LOCKED:
        begin
          if (wbyte == fopt_pkg::CMD_UNLOCK_FIRST)
          begin
            ctl_d = fopt_pkg::FOPT_CTL_FIRST;
          end
          else if (wbyte == fopt_pkg::CMD_GUARD_SELECT)
          begin
            ctl_d = fopt_pkg::FOPT_CTL_GUARD_SEL;
          end
          else
          begin
            ctl_d = fopt_pkg::FOPT_CTL_LOCKED;
          end
        end
        fopt_pkg::FOPT_CTL_FIRST:
        begin
          if (wbyte == fopt_pkg::CMD_UNLOCK_SECOND)
          begin
            ctl_d = fopt_pkg::FOPT_CTL_UNLOCKED;
          end
          else
          begin
            ctl_d = fopt_pkg::FOPT_CTL_LOCKED;
          end
        end
        default: ctl_d = fopt_pkg::FOPT_CTL_LOCKED;
      endcase
    end
    else if (wr_done && paddr == fopt_pkg::ADDR_SECTOR_WRITE_GUARD)
    begin
      // Guard selection is good for one write only
      if (ctl_q == fopt_pkg::FOPT_CTL_GUARD_SEL)
      begin
        ctl_d = fopt_pkg::FOPT_CTL_LOCKED;
      end
    end
  end

  always_ff @(posedge core_clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      ctl_q <= fopt_pkg::FOPT_CTL_LOCKED;
    end
    else
    begin
      ctl_q <= ctl_d;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Software registers: guard, page selector, timing value, trim index
  always_comb
  begin
    guard_d = guard_q;
    page_d = page_q;
    freq_d = freq_q;
    tidx_d = tidx_q;
    if (wr_done)
    begin
      case (paddr)
        fopt_pkg::ADDR_SECTOR_WRITE_GUARD:
        begin
          if (ctl_q == fopt_pkg::FOPT_CTL_GUARD_SEL)
          begin
            // OR only, so a set bit can never be cleared
            guard_d = guard_q | (wbyte & GUARD_MASK);
          end
          else
          begin
            page_d = wbyte;
          end
        end
        fopt_pkg::ADDR_FREQ_HIGH: freq_d = {wbyte, freq_q[7:0]};
        fopt_pkg::ADDR_FREQ_LOW: freq_d = {freq_q[15:8], wbyte};
        fopt_pkg::ADDR_TRIM_INDEX: tidx_d = wbyte;
        default: tidx_d = tidx_q;
      endcase
    end
  end

  always_ff @(posedge core_clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      guard_q <= fopt_pkg::RST_GUARD;
      page_q <= fopt_pkg::RST_PAGE;
      freq_q <= fopt_pkg::RST_FREQ;
      tidx_q <= fopt_pkg::RST_TRIM_INDEX;
    end
    else
    begin
      guard_q <= guard_d;
      page_q <= page_d;
      freq_q <= freq_d;
      tidx_q <= tidx_d;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Option loader: one flash read per step, data caught the cycle after the
  // read strobe, then written into the option byte on an oscillator edge.
  // Stop recovery restarts the sweep exactly as a reset does.
  assign trim_slot = count_q - fopt_pkg::TRIM_INFO_BASE;

  always_comb
  begin
    ld_d = ld_q;
    count_d = count_q;
    faddr_d = faddr_q;
    finfo_d = finfo_q;
    frd_d = 1'b0;
    buf_d = buf_q;
    got_d = got_q;
    busy_d = busy_q;
    opt_d = opt_q;
    if (frd_dly_q)
    begin
      buf_d = flash_rdata;
      got_d = 1'b1;
    end
    if (stop_recovery)
    begin
      ld_d = fopt_pkg::FOPT_LD_READ;
      count_d = 6'h00;
      busy_d = 1'b1;
      got_d = 1'b0;
    end
    else
    begin
      case (ld_q)
        fopt_pkg::FOPT_LD_READ:
        begin
          // Counter feeds the low six bits, all upper bits stay zero
          faddr_d = {10'h000, count_q};
          finfo_d = (count_q > fopt_pkg::PROG_BYTES_LAST);
          frd_d = 1'b1;
          got_d = 1'b0;
          ld_d = fopt_pkg::FOPT_LD_LATCH;
        end
        fopt_pkg::FOPT_LD_LATCH:
        begin
          if (got_q && ipo_rise)
          begin
            opt_d[count_q] = buf_q;
            if (count_q == fopt_pkg::LOAD_LAST)
            begin
              ld_d = fopt_pkg::FOPT_LD_DONE;
              busy_d = 1'b0;
            end
            else
            begin
              count_d = count_q + 6'h01;
              ld_d = fopt_pkg::FOPT_LD_READ;
            end
          end
        end
        fopt_pkg::FOPT_LD_DONE:
        begin
          busy_d = 1'b0;
          finfo_d = 1'b0;
        end
        default:
        begin
          ld_d = fopt_pkg::FOPT_LD_DONE;
          busy_d = 1'b0;
        end
      endcase
    end
  end

  // Option registers change only here, so edits reach them at the next reload
  always_ff @(posedge core_clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      ld_q <= fopt_pkg::FOPT_LD_READ;
      count_q <= 6'h00;
      faddr_q <= 16'h0000;
      finfo_q <= 1'b0;
      frd_q <= 1'b0;
      frd_dly_q <= 1'b0;
      buf_q <= fopt_pkg::RST_BYTE;
      got_q <= 1'b0;
      busy_q <= 1'b1;
      opt_q <= '0;
    end
    else
    begin
      ld_q <= ld_d;
      count_q <= count_d;
      faddr_q <= faddr_d;
      finfo_q <= finfo_d;
      frd_q <= frd_d;
      frd_dly_q <= frd_q;
      buf_q <= buf_d;
      got_q <= got_d;
      busy_q <= busy_d;
      opt_q <= opt_d;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Working trim copies: seeded by the loader from the trim window of the
  // information area on every load, between loads changed only by software. The factory bytes in
  // flash are never written from here, so a power loss restores them.
  always_comb
  begin
    trim_d = trim_q;
    if (ld_q == fopt_pkg::FOPT_LD_LATCH && got_q && ipo_rise && !stop_recovery
        && count_q >= fopt_pkg::TRIM_INFO_BASE)
    begin
      trim_d[trim_slot[4:0]] = buf_q;
    end
    else if (wr_done && paddr == fopt_pkg::ADDR_TRIM_VALUE
             && tidx_q <= fopt_pkg::TRIM_INDEX_MAX)
    begin
      trim_d[tidx_q[4:0]] = wbyte;
    end
  end

  always_ff @(posedge core_clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      trim_q <= '0;
    end
    else
    begin
      trim_q <= trim_d;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Outputs straight from flops
  assign prdata = prdata_q;
  assign pready = pready_q;
  assign pslverr = pslverr_q;
  assign flash_addr = faddr_q;
  assign flash_info_sel = finfo_q;
  assign flash_rd = frd_q;
  assign cpu_hold = busy_q;
  assign option_cfg = opt_q;
  assign trim_work = trim_q;
  assign sector_guard_bit = guard_q;
  assign page_selector = page_q;
  assign program_timing_freq = freq_q;

endmodule

`default_nettype wire

/* File: fopt_flash_model.sv */
`timescale 1ns/10ps
`default_nettype none

////////////////////////////////////////////////////////////////////////////////
module fopt_flash_model (
  // Clock
  input wire logic core_clk,
  // Flash read port
  input wire logic [15:0] flash_addr,
  input wire logic flash_info_sel,
  input wire logic flash_rd,
  output logic [7:0] flash_rdata,
  // Content pattern, changed by the bench to mimic reprogrammed options
  input wire logic [7:0] bias
);
  // Data is valid only in the cycle after the strobe; otherwise it toggles so a late capture shows
  always_ff @(posedge core_clk)
  begin
    if (flash_rd)
      flash_rdata <= {flash_info_sel, 1'b1, flash_addr[5:0]} ^ bias;
    else
      flash_rdata <= ~flash_rdata;
  end
endmodule

`default_nettype wire

/* File: fopt_flash_option_protect_trim_chk.sv */
`timescale 1ns/10ps
`default_nettype none

////////////////////////////////////////////////////////////////////////////////
module fopt_flash_option_protect_trim_chk #(
  parameter int GUARD_BITS_USED = 8
) (
  // Clock and reset
  input wire logic core_clk,
  input wire logic reset_n,
  // APB
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [fopt_pkg::APB_ADDR_W-1:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic pready,
  input wire logic pslverr,
  // Flash and configuration
  input wire logic [15:0] flash_addr,
  input wire logic flash_info_sel,
  input wire logic flash_rd,
  input wire logic cpu_hold,
  input wire logic [fopt_pkg::LOAD_BYTES-1:0][7:0] option_cfg,
  input wire logic [7:0] sector_guard_bit,
  input wire logic [7:0] page_selector,
  input wire logic [15:0] program_timing_freq
);
  localparam logic [7:0] MASK = 8'((1 << GUARD_BITS_USED) - 1);
  logic wr_done;
  logic mapped;

  // Completed write and decoded address
  assign wr_done = psel && penable && pready && pwrite;
  assign mapped = paddr inside {fopt_pkg::ADDR_TRIM_INDEX, fopt_pkg::ADDR_TRIM_VALUE,
    fopt_pkg::ADDR_CONTROLLER_COMMAND, fopt_pkg::ADDR_SECTOR_WRITE_GUARD, fopt_pkg::ADDR_FREQ_HIGH,
    fopt_pkg::ADDR_FREQ_LOW};

  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!reset_n);

  ////////////////////////////////////////////////////////////////////////////////
  hold_stalls_bus_a: assert property (cpu_hold |-> !pready)
    else $error("bus answered during option load");
  load_addr_range_a: assert property (flash_rd |-> flash_addr[15:6] == 10'h000 && flash_addr[5:0] <= 6'h2A)
    else $error("loader address out of range");
  load_source_a: assert property (flash_rd |-> flash_info_sel == (flash_addr[5:0] > 6'h01))
    else $error("loader read from wrong area");
  strobe_single_a: assert property (flash_rd |=> !flash_rd [*2])
    else $error("flash strobe too long");
  guard_sticky_a: assert property (($past(sector_guard_bit) & ~sector_guard_bit) == 8'h00)
    else $error("guard bit cleared");
  guard_or_write_a: assert property ($changed(sector_guard_bit) |->
    $past(wr_done && paddr == fopt_pkg::ADDR_SECTOR_WRITE_GUARD) &&
    sector_guard_bit == (($past(sector_guard_bit) | $past(pwdata[7:0])) & MASK))
    else $error("guard update wrong");
  page_write_a: assert property ($changed(page_selector) |->
    $past(wr_done && paddr == fopt_pkg::ADDR_SECTOR_WRITE_GUARD))
    else $error("page selector changed without write");
  freq_high_a: assert property (wr_done && paddr == fopt_pkg::ADDR_FREQ_HIGH |=>
    program_timing_freq[15:8] == $past(pwdata[7:0]))
    else $error("timing high byte wrong");
  freq_low_a: assert property (wr_done && paddr == fopt_pkg::ADDR_FREQ_LOW |=>
    program_timing_freq[7:0] == $past(pwdata[7:0]))
    else $error("timing low byte wrong");
  unmapped_err_a: assert property (psel && penable && pready |-> pslverr == !mapped)
    else $error("error response wrong");
  option_frozen_a: assert property ($changed(option_cfg) |-> $past(cpu_hold))
    else $error("option bytes changed outside load");

  // Main scenarios reached
  cover property ($fell(cpu_hold));
  cover property ($changed(sector_guard_bit));
  cover property (pready && pslverr);
endmodule

bind fopt_flash_option_protect_trim fopt_flash_option_protect_trim_chk #(.GUARD_BITS_USED(GUARD_BITS_USED)) u_chk (
  .core_clk(core_clk), .reset_n(reset_n), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
  .pwdata(pwdata), .pready(pready), .pslverr(pslverr), .flash_addr(flash_addr), .flash_info_sel(flash_info_sel),
  .flash_rd(flash_rd), .cpu_hold(cpu_hold), .option_cfg(option_cfg), .sector_guard_bit(sector_guard_bit),
  .page_selector(page_selector), .program_timing_freq(program_timing_freq)
);

`default_nettype wire

/* File: fopt_flash_option_protect_trim_bench.sv */
`timescale 1ns/10ps
`default_nettype none

////////////////////////////////////////////////////////////////////////////////
module fopt_flash_option_protect_trim_bench;
  localparam logic [13:0] A_CMD = fopt_pkg::ADDR_CONTROLLER_COMMAND;
  localparam logic [13:0] A_GRD = fopt_pkg::ADDR_SECTOR_WRITE_GUARD;
  localparam logic [13:0] A_TI = fopt_pkg::ADDR_TRIM_INDEX;
  localparam logic [13:0] A_TV = fopt_pkg::ADDR_TRIM_VALUE;
  logic core_clk = 1'b0;
  logic reset_n = 1'b0;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [13:0] paddr = 14'h0000;
  logic [31:0] pwdata = 32'h00000000;
  logic stop_recovery = 1'b0;
  logic osc = 1'b0;
  logic [7:0] bias = 8'h00;
  logic [31:0] prdata;
  logic pready, pslverr, flash_info_sel, flash_rd, cpu_hold;
  logic [15:0] flash_addr, freq;
  logic [7:0] flash_rdata, guard, page;
  logic [fopt_pkg::LOAD_BYTES-1:0][7:0] option_cfg;
  logic [fopt_pkg::TRIM_BYTES-1:0][7:0] trim_work;
  logic [31:0] rdat;
  logic rerr;
  int fail_count = 0;
  int checked = 0;
  logic [13:0] regs [5] = '{A_TI, A_CMD, A_GRD, fopt_pkg::ADDR_FREQ_HIGH, fopt_pkg::ADDR_FREQ_LOW};
  logic [7:0] gw [3] = '{8'h81, 8'h02, 8'h00};
  logic [7:0] ge [3] = '{8'h81, 8'h83, 8'h83};

  // 10 MHz system clock, inside the supported programming range
  always #50 core_clk = ~core_clk;
  // Oscillator with no phase relation to the system clock
  always #165 osc = ~osc;

  fopt_flash_option_protect_trim #(.GUARD_BITS_USED(8)) u_dut (
    .core_clk(core_clk), .reset_n(reset_n), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
    .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr), .stop_recovery(stop_recovery),
    .internal_precision_oscillator(osc), .flash_addr(flash_addr), .flash_info_sel(flash_info_sel),
    .flash_rd(flash_rd), .flash_rdata(flash_rdata), .cpu_hold(cpu_hold), .option_cfg(option_cfg),
    .trim_work(trim_work), .sector_guard_bit(guard), .page_selector(page), .program_timing_freq(freq)
  );

  fopt_flash_model u_flash (
    .core_clk(core_clk), .flash_addr(flash_addr), .flash_info_sel(flash_info_sel), .flash_rd(flash_rd),
    .flash_rdata(flash_rdata), .bias(bias)
  );

  ////////////////////////////////////////////////////////////////////////////////
  // Expected flash content, same pattern the model serves
  function automatic logic [7:0] fexp(input logic inf, input logic [5:0] a);
    return {inf, 1'b1, a} ^ bias;
  endfunction

  task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string what);
    checked++;
    if (got !== exp)
    begin
      fail_count++;
      $display("[FAIL] %0t %s: got %h expected %h", $time, what, got, exp);
    end
  endtask

  // One APB transfer; request held until pready is seen high
  task automatic apb(input logic wr, input logic [13:0] a, input logic [7:0] d);
    int n;
    n = 0;
    @(posedge core_clk);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= {24'h000000, d};
    @(posedge core_clk);
    penable <= 1'b1;
    do
    begin
      @(posedge core_clk);
      n++;
    end
    while (pready !== 1'b1 && n < 100);
    rdat = prdata;
    rerr = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    // Outputs move at the edge that ends the access, so callers look half a cycle later
    @(negedge core_clk);
    if (n >= 100)
      chk(32'h0, 32'h1, "bus timeout");
  endtask

  task automatic rd(input logic [13:0] a, input logic [7:0] e, input logic ee);
    apb(1'b0, a, 8'h00);
    chk(rdat, {24'h000000, e}, "read data");
    chk({31'h0, rerr}, {31'h0, ee}, "error flag");
  endtask

  task automatic wait_load();
    int n;
    n = 0;
    while (cpu_hold !== 1'b0 && n < 3000)
    begin
      @(posedge core_clk);
      n++;
    end
    chk({31'h0, cpu_hold}, 32'h0, "load finished");
  endtask

  task automatic check_opts();
    for (int k = 0; k < fopt_pkg::LOAD_BYTES; k++)
      chk({24'h0, option_cfg[k]}, {24'h0, fexp(k > 1, 6'(k))}, "option byte");
  endtask

  task automatic conclude();
    if (fail_count == 0 && checked > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask

  ////////////////////////////////////////////////////////////////////////////////
  // Main sequence
  initial
  begin
    repeat (16) @(posedge core_clk);
    chk({31'h0, cpu_hold}, 32'h1, "hold in reset");
    reset_n <= 1'b1;
    wait_load();
    check_opts();
    foreach (regs[i]) rd(regs[i], 8'h00, 1'b0);
    rd(14'h3FF0, 8'h00, 1'b1);
    // Timing value for 10 MHz in kilohertz
    apb(1'b1, fopt_pkg::ADDR_FREQ_HIGH, 8'h27);
    apb(1'b1, fopt_pkg::ADDR_FREQ_LOW, 8'h10);
    chk({16'h0, freq}, 32'h2710, "timing value");
    rd(fopt_pkg::ADDR_FREQ_LOW, 8'h10, 1'b0);
    // Plain write reaches the page selector
    apb(1'b1, A_GRD, 8'h55);
    chk({page, guard}, 32'h5500, "page write");
    // Guard command each time; ones accumulate, zeros never clear
    foreach (gw[i])
    begin
      apb(1'b1, A_CMD, fopt_pkg::CMD_GUARD_SELECT);
      apb(1'b1, A_GRD, gw[i]);
      chk({page, guard}, {24'h55, ge[i]}, "guard write");
    end
    // Unlock, then the guard code counts as a bad command and relocks
    apb(1'b1, A_CMD, fopt_pkg::CMD_UNLOCK_FIRST);
    rd(A_CMD, fopt_pkg::STAT_FIRST, 1'b0);
    apb(1'b1, A_CMD, fopt_pkg::CMD_UNLOCK_SECOND);
    rd(A_CMD, fopt_pkg::STAT_UNLOCKED, 1'b0);
    apb(1'b1, A_CMD, fopt_pkg::CMD_GUARD_SELECT);
    rd(A_CMD, fopt_pkg::STAT_LOCKED, 1'b0);
    apb(1'b1, A_GRD, 8'h10);
    chk({page, guard}, 32'h1083, "write after unlock");
    // Working trim seeded from the information area
    apb(1'b1, A_TI, 8'h03);
    rd(A_TV, fexp(1'b1, 6'h23), 1'b0);
    apb(1'b1, A_TI, 8'h0B);
    rd(A_TV, 8'h00, 1'b0);
    for (int i = 0; i < 32; i++)
    begin
      apb(1'b1, A_TI, 8'(i));
      apb(1'b1, A_TV, 8'hC0 ^ 8'(i));
    end
    for (int i = 0; i < 32; i++)
    begin
      apb(1'b1, A_TI, 8'(i));
      rd(A_TV, 8'hC0 ^ 8'(i), 1'b0);
      chk({24'h0, trim_work[i]}, {24'h0, 8'hC0 ^ 8'(i)}, "trim byte");
    end
    // Index past the last trim byte reaches nothing
    apb(1'b1, A_TI, 8'h20);
    apb(1'b1, A_TV, 8'hFF);
    rd(A_TV, 8'h00, 1'b0);
    chk({24'h0, trim_work[0]}, 32'hC0, "trim untouched");
    // Reprogrammed options stay unseen until a reload
    bias <= 8'h5A;
    repeat (100) @(posedge core_clk);
    chk({24'h0, option_cfg[0]}, 32'h40, "options before reload");
    stop_recovery <= 1'b1;
    @(posedge core_clk);
    stop_recovery <= 1'b0;
    repeat (2) @(posedge core_clk);
    chk({31'h0, cpu_hold}, 32'h1, "stop recovery load");
    wait_load();
    check_opts();
    chk({24'h0, guard}, 32'h83, "guard kept");
    // Second reset in mid-run clears guard and timing value
    reset_n <= 1'b0;
    repeat (4) @(posedge core_clk);
    chk({guard, freq}, 32'h0, "reset values");
    reset_n <= 1'b1;
    wait_load();
    check_opts();
    conclude();
  end

  // Watchdog well beyond the expected run of under two thousand cycles
  initial
  begin
    #1_000_000;
    fail_count++;
    conclude();
  end
endmodule

`default_nettype wire
